// *** design/hbp_port.sv ***
/*
  Host bus, interrupt chain, request and clock pin logic of a two-channel
  serial controller. Assumes an outside core supplies configuration,
  interrupt request, vector and transfer readiness.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbp_defs.svh"

module hbp_port #(
  parameter int NCH = 2
) (
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST,
  // bus select: 0 separate strobes, 1 multiplexed
  input  wire logic                       MUX_BUS,
  // separate strobe bus
  input  wire logic                       CHIP_EN_N,
  input  wire logic                       RD_N,
  input  wire logic                       WR_N,
  input  wire logic                       CHAN_SEL,
  input  wire logic                       DATA_CMD_SEL,
  // multiplexed bus
  input  wire logic                       ADDRESS_STROBE_N,
  input  wire logic                       DATA_STROBE_N,
  input  wire logic                       READ_NOT_WRITE,
  input  wire logic                       SELECT_ACTIVE_LOW,
  input  wire logic                       SELECT_ACTIVE_HIGH,
  // shared data lines
  input  wire logic [7:0]                 BUS_IN,
  output logic      [7:0]                 BUS_OUT,
  output logic                            BUS_OE_N,
  // core side access
  output hbp_pkg::hbp_access_s            ACC,
  output logic                            ACC_WR_STB,
  output logic                            ACC_RD_STB,
  output logic      [7:0]                 ACC_WDATA,
  input  wire logic [7:0]                 CORE_RDATA,
  output logic                            BUS_RESET,
  // interrupts
  input  wire logic                       CHAIN_ENABLE_IN,
  output logic                            CHAIN_ENABLE_OUT,
  input  wire logic                       IRQ_ACKNOWLEDGE_STROBE_N,
  input  wire logic                       CORE_IRQ_REQ,
  input  wire logic                       IN_SERVICE_FLAG,
  input  wire logic [7:0]                 CORE_VECTOR,
  output logic                            IRQ_N_OUT,
  output logic                            IRQ_N_OE_N,
  // per channel configuration and dma
  input  wire hbp_pkg::hbp_chan_cfg_s [NCH-1:0] CFG,
  input  wire logic [NCH-1:0]             TX_REQ,
  input  wire logic [NCH-1:0]             WAIT_REQ_ACTIVE,
  output logic      [NCH-1:0]             TERM_READY_N,
  output logic      [NCH-1:0]             WAIT_REQ_OUT,
  output logic      [NCH-1:0]             WAIT_REQ_OE_N,
  // modem inputs and events
  input  wire logic [NCH-1:0]             CLEAR_TO_SEND_N,
  input  wire logic [NCH-1:0]             CARRIER_DETECT_IN_N,
  output logic      [NCH-1:0]             MODEM_EDGE,
  // clock pins
  input  wire logic [NCH-1:0]             RX_TX_CLOCK_PIN,
  input  wire logic [NCH-1:0]             TX_RX_CLOCK_PIN_IN,
  output logic      [NCH-1:0]             TX_RX_CLOCK_PIN_OUT,
  output logic      [NCH-1:0]             TX_RX_CLOCK_PIN_OE_N,
  input  wire logic [NCH-1:0]             RECOVERY_CLK,
  input  wire logic [NCH-1:0]             XTAL_CLK,
  input  wire logic [NCH-1:0]             BAUD_CLK,
  input  wire logic [NCH-1:0]             TX_CLK_INT,
  output logic      [NCH-1:0]             RX_CLK_SEL,
  output logic      [NCH-1:0]             TX_CLK_SEL,
  output logic      [NCH-1:0]             BAUD_SRC_SEL,
  output logic      [NCH-1:0]             RECOVERY_SRC_SEL,
  output logic      [NCH-1:0]             RX_SAMPLE_TICK
);

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  // two stages on master clock
  localparam int NS = 11;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] raw;
  assign raw = {CHIP_EN_N, RD_N, WR_N, CHAN_SEL, DATA_CMD_SEL,
                ADDRESS_STROBE_N, DATA_STROBE_N, READ_NOT_WRITE,
                SELECT_ACTIVE_LOW, SELECT_ACTIVE_HIGH, CHAIN_ENABLE_IN};
  always_ff @(posedge CLK)
  begin
    s1_q <= RST ? '1 : raw;
    s2_q <= RST ? '1 : s1_q;
  end
  logic ce_n, rd_n, wr_n, csel, dcsel, as_n, ds_n, rnw, sel_lo, sel_hi;
  logic chain_enable_in;
  assign {ce_n, rd_n, wr_n, csel, dcsel, as_n, ds_n, rnw, sel_lo, sel_hi,
          chain_enable_in} = s2_q;

  logic ack1_q, ack2_q;
  always_ff @(posedge CLK)
  begin
    ack1_q <= RST ? 1'b1 : IRQ_ACKNOWLEDGE_STROBE_N;
    ack2_q <= RST ? 1'b1 : ack1_q;
  end
  logic in_ack;
  assign in_ack = !ack2_q;

  // data lines sampled twice as well
  logic [7:0] bd1_q, bd2_q;
  always_ff @(posedge CLK)
  begin
    bd1_q <= RST ? 8'h00 : BUS_IN;
    bd2_q <= RST ? 8'h00 : bd1_q;
  end

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic as_d1_q, ds_d1_q, rd_d1_q, wr_d1_q;
  logic [7:0] addr_q;
  logic cs_lat_q;
  always_ff @(posedge CLK)
  begin
    as_d1_q <= RST ? 1'b1 : as_n;
    ds_d1_q <= RST ? 1'b1 : ds_n;
    rd_d1_q <= RST ? 1'b1 : rd_n;
    wr_d1_q <= RST ? 1'b1 : wr_n;
  end

  // address and low select latched on strobe rise
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      addr_q   <= 8'h00;
      cs_lat_q <= 1'b0;
    end
    else if (as_n && !as_d1_q)
    begin
      addr_q   <= bd2_q;
      cs_lat_q <= !sel_lo;
    end
  end

  logic reset_cond;
  assign reset_cond = MUX_BUS ? (!as_n && !ds_n) : (!rd_n && !wr_n);

  logic sel_ok, rd_act, wr_act, rd_start, wr_start;
  assign sel_ok = MUX_BUS ? (cs_lat_q && sel_hi) : !ce_n;
  assign rd_act = MUX_BUS ? (!ds_n && rnw) : !rd_n;
  assign rd_start = MUX_BUS ? (!ds_n && ds_d1_q && rnw)
                            : (!rd_n && rd_d1_q);
  assign wr_start = MUX_BUS ? (!ds_n && ds_d1_q && !rnw)
                            : (!wr_n && wr_d1_q);

  hbp_pkg::hbp_state_e st_q;

  always_ff @(posedge CLK)
  begin
    if (RST)
      BUS_RESET <= 1'b0;
    else
      BUS_RESET <= reset_cond;
  end

  // access strobes; reset condition suppresses them
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ACC        <= '0;
      ACC_WR_STB <= 1'b0;
      ACC_RD_STB <= 1'b0;
      ACC_WDATA  <= 8'h00;
    end
    else
    begin
      ACC_WR_STB <= sel_ok && wr_start && !reset_cond && !in_ack;
      ACC_RD_STB <= sel_ok && rd_start && !reset_cond && !in_ack;
      ACC_WDATA  <= bd2_q;
      ACC.chan_a  <= csel;
      ACC.is_data <= dcsel;
      ACC.is_read <= rd_act;
      ACC.addr    <= MUX_BUS ? addr_q : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // read drive and vector
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
      st_q <= hbp_pkg::HBP_IDLE;
    else
      case (st_q)
        hbp_pkg::HBP_IDLE:
          if (in_ack && rd_act && chain_enable_in)
            st_q <= hbp_pkg::HBP_ACK;
          else if (!in_ack && sel_ok && rd_act && !reset_cond)
            st_q <= hbp_pkg::HBP_ACCESS;
        hbp_pkg::HBP_ACCESS:
          if (!rd_act)
            st_q <= hbp_pkg::HBP_IDLE;
        hbp_pkg::HBP_ACK:
          if (!rd_act)
            st_q <= hbp_pkg::HBP_IDLE;
        default:
          st_q <= hbp_pkg::HBP_IDLE;
      endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      BUS_OUT  <= 8'h00;
      BUS_OE_N <= 1'b1;
    end
    else
    begin
      BUS_OE_N <= (st_q == hbp_pkg::HBP_IDLE);
      BUS_OUT  <= (st_q == hbp_pkg::HBP_ACK) ? CORE_VECTOR : CORE_RDATA;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt chain
  // ----------------------------------------------------------------------
  // upstream chain in is trusted as given
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      CHAIN_ENABLE_OUT <= 1'b0;
      IRQ_N_OUT        <= 1'b0;
      IRQ_N_OE_N       <= 1'b1;
    end
    else
    begin
      CHAIN_ENABLE_OUT <= chain_enable_in && !IN_SERVICE_FLAG
                          && !(in_ack && CORE_IRQ_REQ);
      IRQ_N_OUT  <= 1'b0;
      IRQ_N_OE_N <= !CORE_IRQ_REQ;
    end
  end

  // ----------------------------------------------------------------------
  // per channel logic
  // ----------------------------------------------------------------------
  // modem and clock pins from outside: two stages first
  logic [NCH-1:0] cts1_q, cts2_q, cts3_q, dcd1_q, dcd2_q, dcd3_q;
  logic [NCH-1:0] rtx1_q, rtx2_q, rtx3_q;

  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      logic [2:0] rel_cnt_q;
      logic       tx_req_d1_q;
      logic [5:0] div_q;
      logic [5:0] div_top;

      always_ff @(posedge CLK)
      begin
        cts1_q[g] <= RST ? 1'b1 : CLEAR_TO_SEND_N[g];
        cts2_q[g] <= RST ? 1'b1 : cts1_q[g];
        cts3_q[g] <= RST ? 1'b1 : cts2_q[g];
        dcd1_q[g] <= RST ? 1'b1 : CARRIER_DETECT_IN_N[g];
        dcd2_q[g] <= RST ? 1'b1 : dcd1_q[g];
        dcd3_q[g] <= RST ? 1'b1 : dcd2_q[g];
        rtx1_q[g] <= RST ? 1'b0 : RX_TX_CLOCK_PIN[g];
        rtx2_q[g] <= RST ? 1'b0 : rtx1_q[g];
        rtx3_q[g] <= RST ? 1'b0 : rtx2_q[g];
      end

      always_ff @(posedge CLK)
      begin
        if (RST)
          MODEM_EDGE[g] <= 1'b0;
        else
          MODEM_EDGE[g] <= (cts2_q[g] ^ cts3_q[g])
                           | (dcd2_q[g] ^ dcd3_q[g]);
      end

      // four-clock release after request drops
      always_ff @(posedge CLK)
      begin
        tx_req_d1_q <= RST ? 1'b0 : TX_REQ[g];
        if (RST)
          rel_cnt_q <= 3'h0;
        else if (TX_REQ[g])
          rel_cnt_q <= `HBP_REQ_RELEASE_CYCLES;
        else if (rel_cnt_q != 3'h0)
          rel_cnt_q <= rel_cnt_q - 3'h1;
      end

      always_ff @(posedge CLK)
      begin
        if (RST)
          TERM_READY_N[g] <= 1'b1;
        else if (!CFG[g].cr14[`HBP_CR14_REQ_MODE_BIT])
          TERM_READY_N[g] <= !CFG[g].cr5[`HBP_CR5_TERM_READY_BIT];
        else if (CFG[g].enh[`HBP_ENH_REQ_TIMING_BIT])
          TERM_READY_N[g] <= !WAIT_REQ_ACTIVE[g];
        else
          TERM_READY_N[g] <= !(TX_REQ[g] || rel_cnt_q != 3'h0);
      end

      // wait open drain after reset, request push-pull
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          WAIT_REQ_OUT[g]  <= 1'b0;
          WAIT_REQ_OE_N[g] <= 1'b1;
        end
        else if (CFG[g].req_not_wait)
        begin
          WAIT_REQ_OUT[g]  <= !WAIT_REQ_ACTIVE[g];
          WAIT_REQ_OE_N[g] <= 1'b0;
        end
        else
        begin
          WAIT_REQ_OUT[g]  <= 1'b0;
          WAIT_REQ_OE_N[g] <= !WAIT_REQ_ACTIVE[g];
        end
      end

      always_ff @(posedge CLK)
      begin
        RX_CLK_SEL[g]       <= !RST && CFG[g].rtx_use == 2'h0;
        TX_CLK_SEL[g]       <= !RST && CFG[g].rtx_use == 2'h1;
        BAUD_SRC_SEL[g]     <= !RST && CFG[g].rtx_use == 2'h2;
        RECOVERY_SRC_SEL[g] <= !RST && CFG[g].rtx_use == 2'h3;
      end

      // echo one of four sources when output
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          TX_RX_CLOCK_PIN_OUT[g]  <= 1'b0;
          TX_RX_CLOCK_PIN_OE_N[g] <= 1'b1;
        end
        else
        begin
          TX_RX_CLOCK_PIN_OE_N[g] <= !CFG[g].trx_is_out;
          case (CFG[g].trx_src)
            `HBP_TRX_SRC_RECOVERY: TX_RX_CLOCK_PIN_OUT[g] <= RECOVERY_CLK[g];
            `HBP_TRX_SRC_XTAL:     TX_RX_CLOCK_PIN_OUT[g] <= XTAL_CLK[g];
            `HBP_TRX_SRC_BAUD:     TX_RX_CLOCK_PIN_OUT[g] <= BAUD_CLK[g];
            default:               TX_RX_CLOCK_PIN_OUT[g] <= TX_CLK_INT[g];
          endcase
        end
      end

      // receive clock divide 1, 16, 32 or 64
      always_comb
      begin
        case (CFG[g].rx_div)
          `HBP_RX_DIV_1:  div_top = 6'h00;
          `HBP_RX_DIV_16: div_top = 6'h0F;
          `HBP_RX_DIV_32: div_top = 6'h1F;
          default:        div_top = 6'h3F;
        endcase
      end

      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          div_q             <= 6'h00;
          RX_SAMPLE_TICK[g] <= 1'b0;
        end
        else if (rtx2_q[g] && !rtx3_q[g])
        begin
          div_q             <= (div_q >= div_top) ? 6'h00 : div_q + 6'h01;
          RX_SAMPLE_TICK[g] <= (div_q >= div_top);
        end
        else
          RX_SAMPLE_TICK[g] <= 1'b0;
      end
    end
  endgenerate

endmodule : hbp_port
`default_nettype wire

// *** design/hbp_defs.svh ***
/*
  Constants for the host bus and interrupt chain port: control bit
  positions, clock source encodings and timing counts.
  Assumes a single 200 MHz master clock.
*/
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH

// ----------------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------------
`define HBP_CR14_REQ_MODE_BIT 2
`define HBP_CR5_TERM_READY_BIT 7
`define HBP_ENH_REQ_TIMING_BIT 4

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define HBP_REQ_RELEASE_CYCLES 3'h4

// ----------------------------------------------------------------------
// clock source and receive divider encodings
// ----------------------------------------------------------------------
`define HBP_TRX_SRC_RECOVERY 2'h0
`define HBP_TRX_SRC_XTAL 2'h1
`define HBP_TRX_SRC_BAUD 2'h2
`define HBP_TRX_SRC_TXCLK 2'h3
`define HBP_RX_DIV_1 2'h0
`define HBP_RX_DIV_16 2'h1
`define HBP_RX_DIV_32 2'h2
`define HBP_RX_DIV_64 2'h3

`endif

// *** design/hbp_pkg.sv ***
/*
  Types for the host bus port: decoded access and per-channel config.
  Assumes hbp_defs.svh is included by users needing constants.
*/
package hbp_pkg;
  typedef struct packed {
    logic       chan_a;
    logic       is_data;
    logic       is_read;
    logic [7:0] addr;
  } hbp_access_s;

  typedef struct packed {
    logic [7:0] cr14;
    logic [7:0] cr5;
    logic [7:0] enh;
    logic       req_not_wait;
    logic [1:0] rx_div;
    logic [1:0] rtx_use;
    logic       trx_is_out;
    logic [1:0] trx_src;
  } hbp_chan_cfg_s;

  typedef enum logic [1:0] {
    HBP_IDLE,
    HBP_ACCESS,
    HBP_ACK
  } hbp_state_e;
endpackage : hbp_pkg

// *** tb/hbp_port_monitor.sv ***
/*
  Checker for the host bus port, bound to the top module.
  Assumes one master clock and a synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbp_defs.svh"

module hbp_port_monitor #(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic                             CLK,
  input wire logic                             RST,
  // host bus
  input wire logic                             MUX_BUS,
  input wire logic                             CHIP_EN_N,
  input wire logic                             RD_N,
  input wire logic                             WR_N,
  input wire logic                             ADDRESS_STROBE_N,
  input wire logic                             DATA_STROBE_N,
  input wire logic                             ACC_WR_STB,
  input wire logic                             ACC_RD_STB,
  input wire logic                             BUS_RESET,
  // interrupt chain
  input wire logic                             CHAIN_ENABLE_IN,
  input wire logic                             CHAIN_ENABLE_OUT,
  input wire logic                             IN_SERVICE_FLAG,
  input wire logic                             IRQ_N_OUT,
  input wire logic                             IRQ_N_OE_N,
  // channel pins
  input wire hbp_pkg::hbp_chan_cfg_s [NCH-1:0] CFG,
  input wire logic [NCH-1:0]                   TERM_READY_N,
  input wire logic [NCH-1:0]                   WAIT_REQ_OUT,
  input wire logic [NCH-1:0]                   WAIT_REQ_OE_N
);
  default clocking mon_cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  AST_IRQ_OPEN_DRAIN:
    assert property (!IRQ_N_OE_N |-> !IRQ_N_OUT)
    else $error("interrupt pin driven high");
  // config passes a register first, so judge only settled wait mode
  AST_WAIT_PULL_ONLY:
    assert property (!CFG[0].req_not_wait && !$past(CFG[0].req_not_wait, 3)
      && !WAIT_REQ_OE_N[0] |-> !WAIT_REQ_OUT[0])
    else $error("wait line driven high");
  AST_REQ_DRIVES:
    assert property (CFG[0].req_not_wait [*5] |-> !WAIT_REQ_OE_N[0])
    else $error("request line left floating");
  AST_CHAIN_NEEDS_IN:
    assert property (!CHAIN_ENABLE_IN [*5] |-> !CHAIN_ENABLE_OUT)
    else $error("chain out high with chain in low");
  AST_CHAIN_IN_SERVICE:
    assert property (IN_SERVICE_FLAG [*5] |-> !CHAIN_ENABLE_OUT)
    else $error("chain out high while in service");
  AST_SEP_RESET:
    assert property ((!MUX_BUS && !RD_N && !WR_N) [*5]
      |-> BUS_RESET && !ACC_WR_STB)
    else $error("read plus write not taken as reset");
  AST_MUX_RESET:
    assert property ((MUX_BUS && !ADDRESS_STROBE_N && !DATA_STROBE_N) [*5]
      |-> BUS_RESET)
    else $error("address plus data strobe not taken as reset");
  AST_DESELECTED:
    assert property ((!MUX_BUS && CHIP_EN_N) [*6]
      |-> !ACC_WR_STB && !ACC_RD_STB)
    else $error("access while not selected");
  AST_WRITE_CAUSE:
    assert property (ACC_WR_STB |-> (MUX_BUS ? !$past(DATA_STROBE_N, 2)
      : !$past(WR_N, 2)) ##1 !ACC_WR_STB)
    else $error("write strobe without its cause");
  AST_TERM_LEVEL:
    assert property ((!CFG[0].cr14[`HBP_CR14_REQ_MODE_BIT]
      && $stable(CFG[0])) [*5]
      |-> TERM_READY_N[0] == !CFG[0].cr5[`HBP_CR5_TERM_READY_BIT])
    else $error("terminal ready not inverse of control bit");
  COV_MUX_WRITE: cover property (MUX_BUS && ACC_WR_STB);
  COV_MUX_READ: cover property (MUX_BUS && ACC_RD_STB);
  COV_BUS_RESET: cover property ($rose(BUS_RESET));
  COV_CHAIN_OPEN: cover property ($rose(CHAIN_ENABLE_OUT));
endmodule : hbp_port_monitor

bind hbp_port hbp_port_monitor #(.NCH(NCH)) u_mon (
  .CLK(CLK), .RST(RST), .MUX_BUS(MUX_BUS), .CHIP_EN_N(CHIP_EN_N),
  .RD_N(RD_N), .WR_N(WR_N), .ADDRESS_STROBE_N(ADDRESS_STROBE_N),
  .DATA_STROBE_N(DATA_STROBE_N), .ACC_WR_STB(ACC_WR_STB),
  .ACC_RD_STB(ACC_RD_STB), .BUS_RESET(BUS_RESET),
  .CHAIN_ENABLE_IN(CHAIN_ENABLE_IN), .CHAIN_ENABLE_OUT(CHAIN_ENABLE_OUT),
  .IN_SERVICE_FLAG(IN_SERVICE_FLAG), .IRQ_N_OUT(IRQ_N_OUT),
  .IRQ_N_OE_N(IRQ_N_OE_N), .CFG(CFG), .TERM_READY_N(TERM_READY_N),
  .WAIT_REQ_OUT(WAIT_REQ_OUT), .WAIT_REQ_OE_N(WAIT_REQ_OE_N)
);
`default_nettype wire

// *** tb/hbp_chain_peer.sv ***
/*
  Upstream interrupt chain peer: the higher priority device.
  Assumes the bench says when that device is busy.
*/
`timescale 1ns/1ps
`default_nettype none

module hbp_chain_peer (
  // upstream state
  input  wire logic busy_above,
  // chain
  output logic      chain_en
);
  assign chain_en = !busy_above;
endmodule : hbp_chain_peer
`default_nettype wire

// *** tb/testbench.sv ***
/*
  Self-checking bench for the host bus port: random and corner cases.
  Assumes design files and the chain peer model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hbp_defs.svh"

module testbench;
  logic       clk, rst, mux, ce_n, rd_n, wr_n, ab, dc, as_n, ds_n, sal;
  logic       ack_n, irq, svc, busy, chn_in, chn_out, oe_n, ws, rs, brst;
  logic       io, ioe, rnw;
  logic [7:0] din, dout, rdat, vec, wd, x;
  logic [1:0] txr, wact, trn, wro, woe, cts, rec, xt, bd, txc;
  logic [1:0] tro, troe, rxs, txs, bds, rcs, edg, dcd, rtx, tck;
  logic [6:0] ev;
  int         miscompares, n_compared, k, cnt;
  hbp_pkg::hbp_access_s         acc;
  hbp_pkg::hbp_chan_cfg_s [1:0] cfg;

  // events that waits look for, one bit each
  assign ev = {rs, edg[0], ~trn[0], chn_out, brst, ~oe_n, ws};

  hbp_port #(.NCH(2)) DUT (
    .CLK(clk), .RST(rst), .MUX_BUS(mux), .CHIP_EN_N(ce_n), .RD_N(rd_n),
    .WR_N(wr_n), .CHAN_SEL(ab), .DATA_CMD_SEL(dc), .ADDRESS_STROBE_N(as_n),
    .DATA_STROBE_N(ds_n), .READ_NOT_WRITE(rnw), .SELECT_ACTIVE_LOW(sal),
    .SELECT_ACTIVE_HIGH(1'b1), .BUS_IN(din), .BUS_OUT(dout),
    .BUS_OE_N(oe_n), .ACC(acc), .ACC_WR_STB(ws), .ACC_RD_STB(rs),
    .ACC_WDATA(wd), .CORE_RDATA(rdat), .BUS_RESET(brst),
    .CHAIN_ENABLE_IN(chn_in), .CHAIN_ENABLE_OUT(chn_out),
    .IRQ_ACKNOWLEDGE_STROBE_N(ack_n), .CORE_IRQ_REQ(irq),
    .IN_SERVICE_FLAG(svc), .CORE_VECTOR(vec), .IRQ_N_OUT(io),
    .IRQ_N_OE_N(ioe), .CFG(cfg), .TX_REQ(txr), .WAIT_REQ_ACTIVE(wact),
    .TERM_READY_N(trn), .WAIT_REQ_OUT(wro), .WAIT_REQ_OE_N(woe),
    .CLEAR_TO_SEND_N(cts), .CARRIER_DETECT_IN_N(dcd), .MODEM_EDGE(edg),
    .RX_TX_CLOCK_PIN(rtx), .TX_RX_CLOCK_PIN_IN(2'h0),
    .TX_RX_CLOCK_PIN_OUT(tro), .TX_RX_CLOCK_PIN_OE_N(troe),
    .RECOVERY_CLK(rec), .XTAL_CLK(xt), .BAUD_CLK(bd), .TX_CLK_INT(txc),
    .RX_CLK_SEL(rxs), .TX_CLK_SEL(txs), .BAUD_SRC_SEL(bds),
    .RECOVERY_SRC_SEL(rcs), .RX_SAMPLE_TICK(tck)
  );

  hbp_chain_peer PEER (.busy_above(busy), .chain_en(chn_in));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic conclude();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // bounded wait; a hang ends the run at once
  task automatic wt(input int s);
    for (k = 0; k < 40 && ev[s] !== 1'b1; k++)
      @(negedge clk);
    if (ev[s] !== 1'b1)
    begin
      cmp(ev[s], 1);
      conclude();
    end
  endtask : wt

  // strobes held well past the synchroniser before release
  task automatic sep(input logic rd, input logic [7:0] v);
    {ab, dc, din, rdat} = {v[0], v[7], v, v};
    {ce_n, rd_n, wr_n} = {1'b0, !rd, rd};
    wt(rd ? 6 : 0);
    cmp({rs, ws, acc.is_read}, rd ? 8'h05 : 8'h02);
    cmp({acc.chan_a, acc.is_data}, {v[0], v[7]});
    wt(rd ? 1 : 0);
    cmp(rd ? dout : wd, v);
    repeat (2) @(negedge clk);
    {ce_n, rd_n, wr_n} = 3'h7;
    repeat (6) @(negedge clk);
  endtask : sep

  // receive clock multiple for each divider code
  function automatic int rx_factor(input logic [1:0] d);
    case (d)
      `HBP_RX_DIV_1:  return 1;
      `HBP_RX_DIV_16: return 16;
      `HBP_RX_DIV_32: return 32;
      default:        return 64;
    endcase
  endfunction : rx_factor

  task automatic mux_acc(input logic rd, input logic [7:0] a,
                         input logic [7:0] v);
    {din, sal, as_n, rnw} = {a, 2'b00, rd};
    repeat (3) @(negedge clk);
    as_n = 1;
    repeat (3) @(negedge clk);
    // low select raised after latching: access must still go through
    {din, sal, ds_n, rdat} = {v, 2'b10, v};
    wt(rd ? 6 : 0);
    cmp(acc.is_read, rd);
    wt(rd ? 1 : 0);
    cmp(rd ? dout : wd, v);
    cmp(acc.addr, a);
    repeat (2) @(negedge clk);
    ds_n = 1;
    repeat (4) @(negedge clk);
  endtask : mux_acc

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    {rst, ce_n, rd_n, wr_n, as_n, ds_n, sal, ack_n} = 8'hFF;
    {mux, ab, dc, irq, svc, busy} = 6'h00;
    {din, rdat, vec} = 24'h0;
    {txr, wact, rec, xt, bd, txc} = 12'h0;
    {cts, dcd, rtx, rnw} = 7'h78;
    cfg = '0;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(8416));
    repeat (16) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
    cmp(woe, 8'h03);
    for (int i = 0; i < 20; i++)
    begin
      x = (i < 2) ? {8{i[0]}} : 8'($urandom);
      sep(i > 13, x);
    end
    // both strobes low while selected: reset, never an access
    {ce_n, rd_n, wr_n} = 3'h0;
    wt(2);
    repeat (6) @(negedge clk);
    cmp({brst, ws, rs}, 8'h04);
    {ce_n, rd_n, wr_n} = 3'h7;
    repeat (6) @(negedge clk);
    cmp(brst, 0);
    $display("test separate bus done");
    busy = 1;
    repeat (6) @(negedge clk);
    cmp(chn_out, 0);
    busy = 0;
    wt(3);
    svc = 1;
    repeat (6) @(negedge clk);
    cmp(chn_out, 0);
    {svc, irq, vec} = {2'b01, 8'($urandom)};
    repeat (6) @(negedge clk);
    cmp({chn_out, io, ioe}, 8'h04);
    ack_n = 0;
    repeat (6) @(negedge clk);
    cmp(chn_out, 0);
    rd_n = 0;
    wt(1);
    cmp(dout, vec);
    repeat (2) @(negedge clk);
    {rd_n, ack_n, irq} = 3'b110;
    repeat (6) @(negedge clk);
    cmp(ioe, 1);
    // acknowledge with chain in low must leave the bus alone
    {busy, ack_n, rd_n} = 3'b100;
    repeat (8) @(negedge clk);
    cmp(oe_n, 1);
    {busy, ack_n, rd_n} = 3'b011;
    repeat (6) @(negedge clk);
    $display("test interrupt chain done");
    mux = 1;
    for (int i = 0; i < 6; i++)
      mux_acc(i > 3, 8'($urandom), 8'($urandom));
    {as_n, ds_n} = 2'b00;
    wt(2);
    repeat (6) @(negedge clk);
    cmp(brst, 1);
    {as_n, ds_n} = 2'b11;
    repeat (6) @(negedge clk);
    mux = 0;
    $display("test multiplexed bus done");
    for (int b = 0; b < 2; b++)
    begin
      cfg[0].cr5[`HBP_CR5_TERM_READY_BIT] = b[0];
      repeat (6) @(negedge clk);
      cmp(trn[0], !b[0]);
    end
    // request mode idle: pin no longer follows the control bit
    cfg[0].cr14[`HBP_CR14_REQ_MODE_BIT] = 1;
    cfg[0].enh[`HBP_ENH_REQ_TIMING_BIT] = 0;
    repeat (6) @(negedge clk);
    cmp(trn[0], 1);
    txr[0] = 1;
    wt(4);
    txr[0] = 0;
    repeat (`HBP_REQ_RELEASE_CYCLES) @(negedge clk);
    cmp(trn[0], 0);
    @(negedge clk);
    cmp(trn[0], 1);
    {cfg[0].req_not_wait, wact[0]} = 2'b10;
    repeat (6) @(negedge clk);
    cmp({woe[0], wro[0]}, 8'h01);
    {cfg[0].req_not_wait, wact[0]} = 2'b01;
    repeat (6) @(negedge clk);
    cmp({woe[0], wro[0]}, 0);
    cfg[0].enh[`HBP_ENH_REQ_TIMING_BIT] = 1;
    repeat (6) @(negedge clk);
    cmp(trn[0], 0);
    $display("test request pins done");
    for (int s = 0; s < 4; s++)
    begin
      {cfg[0].rtx_use, cfg[0].trx_src, cfg[0].trx_is_out} = {2'(s), 2'(s), 1'b1};
      cfg[0].rx_div = 2'($urandom);
      {rec, xt, bd, txc} = {{2{s == 0}}, {2{s == 1}}, {2{s == 2}}, {2{s == 3}}};
      repeat (6) @(negedge clk);
      cmp({rcs[0], bds[0], txs[0], rxs[0]}, 4'h1 << s);
      cmp({troe[0], tro[0]}, 2'h1);
    end
    // 64 rises on the clock pin against each divider
    for (int d = 0; d < 4; d++)
    begin
      cfg[0].rx_div = 2'(d);
      cnt = 0;
      for (int r = 0; r < 264; r++)
      begin
        rtx[0] = r[1] && r < 256;
        @(negedge clk);
        cnt += tck[0];
      end
      cmp(8'(cnt), 8'(64 / rx_factor(2'(d))));
    end
    for (int i = 0; i < 4; i++)
    begin
      if (i < 2)
        cts[0] = !cts[0];
      else
        dcd[0] = !dcd[0];
      wt(5);
      @(negedge clk);
      cmp(edg[0], 0);
    end
    $display("test clock and modem pins done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
